// file: tss_pkg.sv
package tss_pkg;

    localparam logic [1:0] RESP_NONE = 2'h0;
    localparam logic [1:0] RESP_SINGLE = 2'h1;
    localparam logic [1:0] RESP_PER_TRIG = 2'h2;
    localparam logic [1:0] RESP_PULSE = 2'h3;

    localparam logic [1:0] SHUT_NORMAL = 2'h0;
    localparam logic [1:0] SHUT_CLOSED = 2'h1;
    localparam logic [1:0] SHUT_OPEN = 2'h2;
    localparam logic [1:0] SHUT_OPEN_BEFORE = 2'h3;

    localparam int EXP_W = 32;
    localparam int FRM_W = 16;
    localparam logic [EXP_W-1:0] EXP_ONE = 32'h1;
    localparam logic [FRM_W-1:0] FRM_ONE = 16'h1;
    localparam logic [EXP_W-1:0] EXP_ZERO = 32'h0;
    localparam logic [FRM_W-1:0] FRM_ZERO = 16'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_WAIT = 3'h1,
        ST_EXPOSE = 3'h3,
        ST_CLOSE = 3'h2,
        ST_READ = 3'h6,
        ST_DONE = 3'h7
    } tss_state_t;

    typedef struct packed {
        logic [1:0] response;
        logic [1:0] shutter;
        logic edge_select;
        logic [EXP_W-1:0] exp_cycles;
        logic [FRM_W-1:0] frames;
    } tss_cfg_t;

    typedef struct packed {
        tss_state_t state;
        tss_cfg_t cfg;
        logic trig_prev;
        logic [EXP_W-1:0] exp_cnt;
        logic [FRM_W-1:0] frm_cnt;
        logic shutter_open;
        logic readout_start;
        logic busy;
        logic exposing;
        logic frame_done;
    } tss_state_reg_t;

endpackage : tss_pkg

// file: tss_edge.sv
`timescale 1ns/1ps
// Qualifying and releasing edge detector for the trigger input.
module tss_edge (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Trigger
    input wire logic trig_in,
    input wire logic edge_select,
    // Edges and registered trigger level
    output logic start_edge,
    output logic end_edge,
    output logic trig_q
);
    logic prev_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= trig_in;
        end
    end

    // Falling selection swaps the roles of both edges.
    always_comb begin
        start_edge = edge_select ? (prev_q & ~trig_in) : (~prev_q & trig_in);
        end_edge = edge_select ? (~prev_q & trig_in) : (prev_q & ~trig_in);
        trig_q = prev_q;
    end
endmodule : tss_edge

// file: tss_sequencer.sv
`timescale 1ns/1ps
module tss_sequencer (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Configuration
    input wire logic [1:0] response,
    input wire logic [1:0] shutter_mode,
    input wire logic edge_select,
    input wire logic [tss_pkg::EXP_W-1:0] exp_cycles,
    input wire logic [tss_pkg::FRM_W-1:0] frame_count,
    input wire logic acq_start,
    // Trigger
    input wire logic trig_in,
    // Readout engine
    input wire logic readout_done,
    // Outputs
    output logic shutter_drive,
    output logic readout_start,
    output logic busy,
    output logic exposing,
    output logic frame_done
);
    tss_pkg::tss_state_reg_t s_q;
    tss_pkg::tss_state_reg_t s_d;
    logic start_edge;
    logic end_edge;
    logic trig_seen;
    logic gated;

    tss_edge u_edge (
        .clk(clk),
        .rstn(rstn),
        .trig_in(trig_in),
        .edge_select(s_q.cfg.edge_select),
        .start_edge(start_edge),
        .end_edge(end_edge),
        .trig_q(trig_seen)
    );

    // Idle shutter level for the latched setting between frames.
    function automatic logic rest_open(input logic [1:0] sm);
        rest_open = (sm == tss_pkg::SHUT_OPEN) || (sm == tss_pkg::SHUT_OPEN_BEFORE);
    endfunction : rest_open

    always_comb begin
        s_d = s_q;
        s_d.readout_start = 1'b0;
        s_d.frame_done = 1'b0;
        s_d.trig_prev = trig_seen;
        gated = 1'b0;
        case (s_q.state)
            tss_pkg::ST_IDLE: begin
                if (acq_start) begin
                    // Configuration is latched only here, so live changes never bite.
                    s_d.cfg.response = response;
                    s_d.cfg.shutter = shutter_mode;
                    s_d.cfg.edge_select = edge_select;
                    s_d.cfg.exp_cycles = (exp_cycles == tss_pkg::EXP_ZERO) ?
                        tss_pkg::EXP_ONE : exp_cycles;
                    s_d.cfg.frames = (frame_count == tss_pkg::FRM_ZERO) ?
                        tss_pkg::FRM_ONE : frame_count;
                    s_d.frm_cnt = tss_pkg::FRM_ZERO;
                    s_d.busy = 1'b1;
                    s_d.state = tss_pkg::ST_WAIT;
                    s_d.shutter_open = rest_open(shutter_mode);
                end
            end
            tss_pkg::ST_WAIT: begin
                // Single-trigger mode needs its edge only before the first frame.
                if (s_q.cfg.response == tss_pkg::RESP_NONE) begin
                    gated = 1'b1;
                end else if (s_q.cfg.response == tss_pkg::RESP_SINGLE &&
                             s_q.frm_cnt != tss_pkg::FRM_ZERO) begin
                    gated = 1'b1;
                end else begin
                    gated = start_edge;
                end
                if (gated) begin
                    s_d.state = tss_pkg::ST_EXPOSE;
                    s_d.exposing = 1'b1;
                    s_d.exp_cnt = s_q.cfg.exp_cycles;
                    s_d.shutter_open = (s_q.cfg.shutter != tss_pkg::SHUT_CLOSED);
                end
            end
            tss_pkg::ST_EXPOSE: begin
                // Edges other than the pulse end are dropped here.
                if (s_q.cfg.response == tss_pkg::RESP_PULSE) begin
                    if (end_edge) begin
                        s_d.state = tss_pkg::ST_CLOSE;
                    end
                end else if (s_q.exp_cnt == tss_pkg::EXP_ONE) begin
                    s_d.state = tss_pkg::ST_CLOSE;
                end else begin
                    s_d.exp_cnt = s_q.exp_cnt - tss_pkg::EXP_ONE;
                end
                if (s_d.state == tss_pkg::ST_CLOSE) begin
                    s_d.exposing = 1'b0;
                    s_d.shutter_open = (s_q.cfg.shutter == tss_pkg::SHUT_OPEN);
                end
            end
            tss_pkg::ST_CLOSE: begin
                // Readout starts only after the close command has been out a cycle.
                s_d.readout_start = 1'b1;
                s_d.state = tss_pkg::ST_READ;
            end
            tss_pkg::ST_READ: begin
                if (readout_done) begin
                    s_d.frame_done = 1'b1;
                    s_d.frm_cnt = s_q.frm_cnt + tss_pkg::FRM_ONE;
                    s_d.shutter_open = rest_open(s_q.cfg.shutter);
                    s_d.state = (s_q.frm_cnt + tss_pkg::FRM_ONE == s_q.cfg.frames) ?
                        tss_pkg::ST_DONE : tss_pkg::ST_WAIT;
                end
            end
            tss_pkg::ST_DONE: begin
                s_d.busy = 1'b0;
                // An idle sequencer leaves the shutter shut, even in the always-open setting.
                s_d.shutter_open = 1'b0;
                s_d.state = tss_pkg::ST_IDLE;
            end
            default: begin
                s_d.state = tss_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign shutter_drive = s_q.shutter_open;
    assign readout_start = s_q.readout_start;
    assign busy = s_q.busy;
    assign exposing = s_q.exposing;
    assign frame_done = s_q.frame_done;

    chk_closed_shut: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.busy && s_q.cfg.shutter == tss_pkg::SHUT_CLOSED) |-> !shutter_drive)
        else $error("Shutter driven in always-closed setting.");

    chk_open_shut: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.busy && s_q.cfg.shutter == tss_pkg::SHUT_OPEN) |-> shutter_drive)
        else $error("Shutter released in always-open setting.");

    chk_close_read: assert property (@(posedge clk) disable iff (!rstn)
        readout_start |-> $past(s_q.state) == tss_pkg::ST_CLOSE &&
        (s_q.cfg.shutter == tss_pkg::SHUT_OPEN || !shutter_drive))
        else $error("Readout started before shutter closed.");

    chk_normal_open: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.state == tss_pkg::ST_EXPOSE && s_q.cfg.shutter == tss_pkg::SHUT_NORMAL)
        |-> shutter_drive)
        else $error("Shutter closed during normal exposure.");

    chk_pertrig_edge: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.state == tss_pkg::ST_WAIT && s_q.cfg.response == tss_pkg::RESP_PER_TRIG &&
        !start_edge) |=> s_q.state == tss_pkg::ST_WAIT)
        else $error("Exposure began without a trigger edge.");

    chk_exp_len: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.state == tss_pkg::ST_EXPOSE && s_q.cfg.response != tss_pkg::RESP_PULSE &&
        s_q.exp_cnt == tss_pkg::EXP_ONE) |=> s_q.state == tss_pkg::ST_CLOSE)
        else $error("Exposure did not end when count expired.");

    chk_pulse_end: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.state == tss_pkg::ST_EXPOSE && s_q.cfg.response == tss_pkg::RESP_PULSE &&
        !end_edge) |=> s_q.state == tss_pkg::ST_EXPOSE)
        else $error("Pulse exposure ended without trigger end edge.");

    chk_shut_reopen: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.state == tss_pkg::ST_READ && readout_done &&
        s_q.cfg.shutter == tss_pkg::SHUT_OPEN_BEFORE) |=> shutter_drive)
        else $error("Shutter not reopened after readout.");

    chk_cfg_hold: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.state != tss_pkg::ST_IDLE) |=> $stable(s_q.cfg))
        else $error("Configuration changed while busy.");

    chk_none_free: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.state == tss_pkg::ST_WAIT && s_q.cfg.response == tss_pkg::RESP_NONE)
        |=> s_q.state == tss_pkg::ST_EXPOSE)
        else $error("No-response mode waited for a trigger.");

    chk_single_free: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.state == tss_pkg::ST_WAIT && s_q.cfg.response == tss_pkg::RESP_SINGLE &&
        s_q.frm_cnt != tss_pkg::FRM_ZERO) |=> s_q.state == tss_pkg::ST_EXPOSE)
        else $error("Single-trigger series waited for a further trigger.");

    chk_read_hold: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.state == tss_pkg::ST_READ && !readout_done) |=> s_q.state == tss_pkg::ST_READ)
        else $error("Readout left before the readout engine finished.");

    chk_early_open: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.state == tss_pkg::ST_WAIT && s_q.cfg.shutter == tss_pkg::SHUT_OPEN_BEFORE)
        |-> shutter_drive)
        else $error("Shutter not open while waiting in open-before setting.");

    chk_pulse_start: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.state == tss_pkg::ST_WAIT && s_q.cfg.response == tss_pkg::RESP_PULSE &&
        start_edge) |=> (s_q.state == tss_pkg::ST_EXPOSE && exposing))
        else $error("Pulse exposure did not begin on the start edge.");

    chk_idle_shut: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.state == tss_pkg::ST_IDLE) |-> !shutter_drive)
        else $error("Shutter left open while idle.");
endmodule : tss_sequencer

// file: tss_far_end.sv
`timescale 1ns/1ps
// Far side of the sequencer: the experiment's trigger source and the readout engine.
module tss_far_end #(
    parameter int RD_LAT = 4
) (
    // Clock
    input wire logic clk,
    // Readout engine
    input wire logic readout_start,
    output logic readout_done,
    // Trigger source
    output logic trig_in
);
    int rd_lat = RD_LAT;
    initial begin
        readout_done = 1'b0;
        trig_in = 1'b0;
    end
    // A readout takes a scan time before the engine reports that it has finished.
    always @(posedge clk) begin
        if (readout_start === 1'b1) begin
            repeat (rd_lat) @(posedge clk);
            #1;
            readout_done = 1'b1;
            @(posedge clk);
            #1;
            readout_done = 1'b0;
        end
    end
    task automatic set_trig(input logic v);
        @(posedge clk);
        #1;
        trig_in = v;
    endtask : set_trig
    // Pulses go out ahead of any wanted light, leaving the shutter its opening time.
    task automatic pulse(input logic idle, input int w);
        set_trig(~idle);
        repeat (w) @(posedge clk);
        #1;
        trig_in = idle;
    endtask : pulse
endmodule : tss_far_end

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] response = 2'h0;
    logic [1:0] shutter_mode = 2'h0;
    logic edge_select = 1'b0;
    logic [tss_pkg::EXP_W-1:0] exp_cycles = 32'h1;
    logic [tss_pkg::FRM_W-1:0] frame_count = 16'h1;
    logic acq_start = 1'b0;
    logic trig_in, readout_done, shutter_drive, readout_start, busy, exposing, frame_done;
    logic sh_exp, sh_rd;
    int err_count = 0;
    int n_checks = 0;
    int exp_len = 0;
    int n_rd = 0;
    int n_fd = 0;
    int sh_bad = 0;
    always #5 clk = ~clk;
    tss_sequencer i_tss_sequencer (.clk(clk), .rstn(rstn), .response(response),
        .shutter_mode(shutter_mode), .edge_select(edge_select), .exp_cycles(exp_cycles),
        .frame_count(frame_count), .acq_start(acq_start), .trig_in(trig_in),
        .readout_done(readout_done), .shutter_drive(shutter_drive),
        .readout_start(readout_start), .busy(busy), .exposing(exposing),
        .frame_done(frame_done));
    tss_far_end i_tss_far_end (.clk(clk), .readout_start(readout_start),
        .readout_done(readout_done), .trig_in(trig_in));
    // Registered outputs are sampled at the edge, so each counts the cycle before it.
    always @(posedge clk) begin
        if (exposing === 1'b1) begin
            exp_len++;
            if (shutter_drive !== sh_exp) sh_bad++;
        end
        if (readout_start === 1'b1) begin
            n_rd++;
            sh_rd = shutter_drive;
        end
        if (frame_done === 1'b1) n_fd++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        n_checks++;
        if (seen !== expd) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask : check
    task automatic start(input logic [1:0] r, input logic [1:0] s, input logic e,
                         input int x, input int f);
        @(posedge clk);
        #1;
        response = r;
        shutter_mode = s;
        edge_select = e;
        exp_cycles = 32'(x);
        frame_count = 16'(f);
        acq_start = 1'b1;
        exp_len = 0;
        n_rd = 0;
        n_fd = 0;
        sh_bad = 0;
        sh_exp = (s != tss_pkg::SHUT_CLOSED);
        @(posedge clk);
        #1;
        acq_start = 1'b0;
    endtask : start
    task automatic wait_fd(input int n);
        int k;
        k = 0;
        while (n_fd < n && k < 300) begin
            @(posedge clk);
            k++;
        end
        #1;
        if (k >= 300) err_count++;
    endtask : wait_fd
    task automatic series_end(input int f, input int len, input logic rs);
        wait_fd(f);
        repeat (2) @(posedge clk);
        #1;
        check(busy, 1'b0);
        check(shutter_drive, 1'b0);
        check(32'(n_rd), 32'(f));
        check(32'(exp_len), 32'(len));
        check(32'(sh_bad), 32'h0);
        check(sh_rd, rs);
    endtask : series_end
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #100000;
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge clk);
        #1;
        rstn = 1'b1;
        for (int s = 0; s < 4; s++) begin
            start(tss_pkg::RESP_PER_TRIG, 2'(s), 1'b0, 5, 2);
            for (int f = 0; f < 2; f++) begin
                repeat (6) @(posedge clk);
                #1;
                check(32'(exp_len), 32'(5 * f));
                check(shutter_drive, s[1]);
                i_tss_far_end.pulse(1'b0, 2);
                i_tss_far_end.pulse(1'b0, 1);
                wait_fd(f + 1);
            end
            series_end(2, 10, s == 2);
        end
        i_tss_far_end.rd_lat = 12;
        start(tss_pkg::RESP_SINGLE, tss_pkg::SHUT_NORMAL, 1'b0, 4, 3);
        repeat (8) @(posedge clk);
        #1;
        check(32'(n_rd), 32'h0);
        i_tss_far_end.pulse(1'b0, 2);
        series_end(3, 12, 1'b0);
        i_tss_far_end.rd_lat = 1;
        start(tss_pkg::RESP_NONE, tss_pkg::SHUT_NORMAL, 1'b0, 3, 2);
        series_end(2, 6, 1'b0);
        start(tss_pkg::RESP_PER_TRIG, tss_pkg::SHUT_NORMAL, 1'b0, 3, 1);
        response = tss_pkg::RESP_NONE;
        shutter_mode = tss_pkg::SHUT_OPEN;
        exp_cycles = 32'h9;
        repeat (8) @(posedge clk);
        #1;
        check(32'(n_rd), 32'h0);
        i_tss_far_end.pulse(1'b0, 2);
        series_end(1, 3, 1'b0);
        for (int e = 0; e < 2; e++) begin
            i_tss_far_end.set_trig(e[0]);
            start(tss_pkg::RESP_PULSE, tss_pkg::SHUT_OPEN_BEFORE, e[0], 2, 1);
            repeat (4) @(posedge clk);
            #1;
            check(shutter_drive, 1'b1);
            i_tss_far_end.pulse(e[0], 7);
            series_end(1, 7, 1'b0);
        end
        give_verdict();
    end
endmodule : testbench
